/* File: can_regs.vh */
`ifndef CAN_REGS_VH
`define CAN_REGS_VH

// Register indices; byte address on APB is four times the index
`define CANRM_IDX_MODE 8'h00
`define CANRM_IDX_CMD 8'h01
`define CANRM_IDX_STATUS 8'h02
`define CANRM_IDX_IFLAGS 8'h03
`define CANRM_IDX_IEN 8'h04
`define CANRM_IDX_BTA 8'h06
`define CANRM_IDX_BTB 8'h07
`define CANRM_IDX_ODC 8'h08
`define CANRM_IDX_ARB 8'h0b
`define CANRM_IDX_BEC 8'h0c
`define CANRM_IDX_EWT 8'h0d
`define CANRM_IDX_RXFC 8'h0e
`define CANRM_IDX_TXFC 8'h0f
`define CANRM_IDX_WIN_LO 8'h10
`define CANRM_IDX_WIN_HI 8'h1c
`define CANRM_IDX_PAT0 8'h10
`define CANRM_IDX_DC0 8'h14
`define CANRM_IDX_RSV_LO 8'h18
`define CANRM_IDX_PEND 8'h1d
`define CANRM_IDX_RXB 8'h1e
`define CANRM_IDX_CDIV 8'h1f
`define CANRM_IDX_TXRB_LO 8'h60
`define CANRM_IDX_TXRB_HI 8'h6c
`define CANRM_IDX_RSV_TOP 8'h7f
`define CANRM_IDX_EVT 8'h80
`define CANRM_IDX_EVT_MASK 8'h81

// Field positions
`define CANRM_MODE_RESET 0
`define CANRM_MODE_DUAL 3
`define CANRM_EVT_RX 0
`define CANRM_EVT_ARB 6

// Reset values
`define CANRM_RST_MODE 8'h01
`define CANRM_RST_CDIV 8'hc0
`define CANRM_RST_EWT 8'h60
`define CANRM_RST_ZERO 8'h00

`endif

/* File: canrm_top.v */
// Behaviour
// - Timing, driver, limit, counters, rx base locked outside reset mode.
// - Command register is write-only; reads always return zero.
// - Operating writes to 10h-1Ch fill tx buffer; read back at 60h-6Ch.
// - Reset mode: 18h-1Ch read zero; 10h-17h hold pattern and mask.
// - Offsets 6Dh-7Fh ignore writes and read zero.
// - Four 8-bit pattern registers feed the acceptance filter with masks.
// - Pattern registers reachable only in reset mode; else tx/rx window.
// - Don't-care registers at 14h-17h, reachable only in reset mode.
// - Mask bit zero forces a match on that bit; one means don't care.
// - Compared bits depend on single/dual filter and standard/extended id.
// - Arbitration loss raises irq when both its enable bit and event mask bit are set, and captures position.
// - Captured position holds through later losses until it is read.
// - Position register bits 7:5 read zero; code sits in bits 4:0.
// - Codes 0..10 mean loss at identifier bits ID.28 down to ID.18.
// - Code 11 marks substitute remote bit, code 12 the extension bit.
`timescale 1ns/10ps
`include "can_regs.vh"

module canrm_top (
  input wire clk,
  input wire rst_n,
  input wire [9:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] engine_status,
  input wire [7:0] engine_err_code,
  input wire [7:0] engine_pending,
  input wire [103:0] rx_window,
  input wire arb_lost,
  input wire [4:0] arb_pos,
  input wire rx_check,
  input wire [28:0] rx_id,
  input wire rx_rtr,
  input wire rx_ext,
  output reg rx_accept,
  output reg rx_accept_valid,
  output reg [7:0] cmd_pulse,
  output reg reset_mode,
  output reg [103:0] tx_frame,
  output reg irq
);

  reg [7:0] mode_control;
  reg [7:0] interrupt_enables;
  reg [7:0] bit_timing_a;
  reg [7:0] bit_timing_b;
  reg [7:0] output_driver_config;
  reg [4:0] arb_lost_position;
  reg arb_armed;
  reg [7:0] error_warning_threshold;
  reg [7:0] rx_fault_count;
  reg [7:0] tx_fault_count;
  reg [31:0] filter_pattern;
  reg [31:0] filter_dontcare;
  reg [7:0] rx_window_base;
  reg [7:0] clock_out_divider;
  reg [7:0] evt_flags;
  reg [7:0] evt_mask;
  reg [7:0] next_rdata;
  reg [7:0] next_evt;
  reg next_accept;

  wire [7:0] idx;
  wire setup_ph;
  wire done;
  wire wr;
  wire rd;
  wire in_reset;
  wire bad_addr;
  wire [7:0] wbyte;
  wire [3:0] win_sel;
  wire [3:0] txr_sel;
  wire [7:0] txr_off;
  wire [7:0] iflags;
  wire arb_capture;
  wire arb_read;
  reg arb_read_ok;

  assign idx = paddr[9:2];
  assign setup_ph = psel & ~penable;
  // Completion edge: the only edge where side effects occur
  assign done = psel & penable & pready & ~pslverr;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign in_reset = mode_control[`CANRM_MODE_RESET];
  // Misaligned or out-of-map accesses are refused with an error
  // and leave every register untouched
  assign bad_addr = (idx > `CANRM_IDX_EVT_MASK) | (paddr[1:0] != 2'b00);
  assign wbyte = pwdata[7:0];
  assign win_sel = idx[3:0] - 4'h0;
  assign txr_off = idx - `CANRM_IDX_TXRB_LO;
  assign txr_sel = txr_off[3:0];
  assign iflags = evt_flags & interrupt_enables;
  // Capture outranks a rearm that falls on the same edge
  assign arb_capture = arb_lost & arb_armed;
  assign arb_read = rd & (idx == `CANRM_IDX_ARB);

  // Bitwise match: mask one means don't care, zero demands equality
  function match;
    input [31:0] data;
    input [31:0] code;
    input [31:0] dontcare;
    begin
      match = &(~(data ^ code) | dontcare);
    end
  endfunction

  // Pick a byte out of a flat 13-byte window
  function [7:0] byte_of;
    input [103:0] flat;
    input [3:0] sel;
    begin
      byte_of = flat[sel * 8 +: 8];
    end
  endfunction

  // Inclusive range test on register indices
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // Acceptance decision for the frame presented on rx_check
  // Purely combinational from the frame fields; the engine must hold
  // them stable in the cycle it raises rx_check
  always @* begin
    next_accept = 1'b0;
    case ({mode_control[`CANRM_MODE_DUAL], rx_ext})
      2'b00: begin
        // Single filter, standard id: id bits and remote bit
        next_accept = match({rx_id[28:18], rx_rtr, 20'h00000},
          filter_pattern, {filter_dontcare[31:20], 20'hfffff});
      end
      2'b01: begin
        // Single filter, extended id: all 29 id bits and remote bit
        next_accept = match({rx_id, rx_rtr, 2'b00},
          filter_pattern, {filter_dontcare[31:2], 2'b11});
      end
      2'b10: begin
        // Dual filter, standard id: two 12-bit filters
        next_accept =
          match({rx_id[28:18], rx_rtr, 20'h00000},
            {filter_pattern[31:20], 20'h00000},
            {filter_dontcare[31:20], 20'hfffff}) |
          match({rx_id[28:18], rx_rtr, 20'h00000},
            {filter_pattern[15:4], 20'h00000},
            {filter_dontcare[15:4], 20'hfffff});
      end
      2'b11: begin
        // Dual filter, extended id: top 16 id bits per filter
        next_accept =
          match({rx_id[28:13], 16'h0000},
            {filter_pattern[31:16], 16'h0000},
            {filter_dontcare[31:16], 16'hffff}) |
          match({rx_id[28:13], 16'h0000},
            {filter_pattern[15:0], 16'h0000},
            {filter_dontcare[15:0], 16'hffff});
      end
      default: next_accept = 1'b0;
    endcase
  end

  // Read multiplexer, evaluated in the setup phase
  // Unmapped indices, the receive fifo span included, fall through to zero
  always @* begin
    next_rdata = 8'h00;
    if (idx == `CANRM_IDX_MODE) begin
      next_rdata = mode_control;
    end else if (idx == `CANRM_IDX_CMD) begin
      next_rdata = 8'h00;
    end else if (idx == `CANRM_IDX_STATUS) begin
      next_rdata = engine_status;
    end else if (idx == `CANRM_IDX_IFLAGS) begin
      next_rdata = iflags;
    end else if (idx == `CANRM_IDX_IEN) begin
      next_rdata = interrupt_enables;
    end else if (idx == `CANRM_IDX_BTA) begin
      next_rdata = bit_timing_a;
    end else if (idx == `CANRM_IDX_BTB) begin
      next_rdata = bit_timing_b;
    end else if (idx == `CANRM_IDX_ODC) begin
      next_rdata = output_driver_config;
    end else if (idx == `CANRM_IDX_ARB) begin
      next_rdata = {3'b000, arb_lost_position};
    end else if (idx == `CANRM_IDX_BEC) begin
      next_rdata = engine_err_code;
    end else if (idx == `CANRM_IDX_EWT) begin
      next_rdata = error_warning_threshold;
    end else if (idx == `CANRM_IDX_RXFC) begin
      next_rdata = rx_fault_count;
    end else if (idx == `CANRM_IDX_TXFC) begin
      next_rdata = tx_fault_count;
    end else if (in_range(idx, `CANRM_IDX_WIN_LO, `CANRM_IDX_WIN_HI)) begin
      // Same addresses name different registers in the two modes
      if (!in_reset) begin
        next_rdata = byte_of(rx_window, win_sel);
      end else if (idx < `CANRM_IDX_DC0) begin
        next_rdata = filter_pattern[(3 - idx[1:0]) * 8 +: 8];
      end else if (idx < `CANRM_IDX_RSV_LO) begin
        next_rdata = filter_dontcare[(3 - idx[1:0]) * 8 +: 8];
      end else begin
        next_rdata = 8'h00;
      end
    end else if (idx == `CANRM_IDX_PEND) begin
      next_rdata = engine_pending;
    end else if (idx == `CANRM_IDX_RXB) begin
      next_rdata = rx_window_base;
    end else if (idx == `CANRM_IDX_CDIV) begin
      next_rdata = clock_out_divider;
    end else if (in_range(idx, `CANRM_IDX_TXRB_LO, `CANRM_IDX_TXRB_HI)) begin
      next_rdata = byte_of(tx_frame, txr_sel);
    end else if (idx == `CANRM_IDX_EVT) begin
      next_rdata = evt_flags;
    end else if (idx == `CANRM_IDX_EVT_MASK) begin
      next_rdata = evt_mask;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // APB handshake: one wait-free access phase after each setup
  // Read data is frozen at the setup edge, so a register that changes
  // during the access phase returns its value from one cycle earlier
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & bad_addr;
      if (setup_ph) begin
        prdata <= {24'h000000, (bad_addr ? 8'h00 : next_rdata)};
      end
    end
  end

  // Software-written configuration, gated by mode
  // Error counters are software-only here; the engine that would
  // update them sits outside this block
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_control <= `CANRM_RST_MODE;
      interrupt_enables <= `CANRM_RST_ZERO;
      bit_timing_a <= `CANRM_RST_ZERO;
      bit_timing_b <= `CANRM_RST_ZERO;
      output_driver_config <= `CANRM_RST_ZERO;
      error_warning_threshold <= `CANRM_RST_EWT;
      rx_fault_count <= `CANRM_RST_ZERO;
      tx_fault_count <= `CANRM_RST_ZERO;
      rx_window_base <= `CANRM_RST_ZERO;
      clock_out_divider <= `CANRM_RST_CDIV;
      filter_pattern <= 32'h00000000;
      filter_dontcare <= 32'hffffffff;
      evt_mask <= `CANRM_RST_ZERO;
      cmd_pulse <= `CANRM_RST_ZERO;
      tx_frame <= 104'h0;
    end else begin
      cmd_pulse <= (wr && idx == `CANRM_IDX_CMD) ? wbyte : 8'h00;
      if (wr) begin
        if (idx == `CANRM_IDX_MODE) begin
          mode_control <= wbyte;
        end
        if (idx == `CANRM_IDX_IEN) begin
          interrupt_enables <= wbyte;
        end
        if (idx == `CANRM_IDX_CDIV) begin
          clock_out_divider <= wbyte;
        end
        if (idx == `CANRM_IDX_EVT_MASK) begin
          evt_mask <= wbyte;
        end
        // Protected settings change only while held in reset mode
        if (in_reset) begin
          if (idx == `CANRM_IDX_BTA) bit_timing_a <= wbyte;
          if (idx == `CANRM_IDX_BTB) bit_timing_b <= wbyte;
          if (idx == `CANRM_IDX_ODC) output_driver_config <= wbyte;
          if (idx == `CANRM_IDX_EWT) error_warning_threshold <= wbyte;
          if (idx == `CANRM_IDX_RXFC) rx_fault_count <= wbyte;
          if (idx == `CANRM_IDX_TXFC) tx_fault_count <= wbyte;
          if (idx == `CANRM_IDX_RXB) rx_window_base <= wbyte;
          if (in_range(idx, `CANRM_IDX_PAT0, `CANRM_IDX_DC0 - 8'h01)) begin
            filter_pattern[(3 - idx[1:0]) * 8 +: 8] <= wbyte;
          end
          if (in_range(idx, `CANRM_IDX_DC0, `CANRM_IDX_RSV_LO - 8'h01)) begin
            filter_dontcare[(3 - idx[1:0]) * 8 +: 8] <= wbyte;
          end
        end else if (in_range(idx, `CANRM_IDX_WIN_LO,
                              `CANRM_IDX_WIN_HI)) begin
          tx_frame[win_sel * 8 +: 8] <= wbyte;
        end
      end
    end
  end

  // Sticky events: a new event beats a same-cycle clear
  // so an event arriving during the clearing write is never lost
  always @* begin
    next_evt = evt_flags;
    if (wr && idx == `CANRM_IDX_EVT) begin
      next_evt = evt_flags & ~wbyte;
    end
    if (arb_lost) begin
      next_evt[`CANRM_EVT_ARB] = 1'b1;
    end
    if (rx_check && next_accept) begin
      next_evt[`CANRM_EVT_RX] = 1'b1;
    end
  end

  // Whether the byte being read is the position now held; a capture on
  // the setup edge is newer than what software will see
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_read_ok <= 1'b0;
    end else if (setup_ph && idx == `CANRM_IDX_ARB) begin
      arb_read_ok <= ~arb_capture;
    end
  end

  // Arbitration capture, rearmed only by a completed read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_lost_position <= 5'h00;
      arb_armed <= 1'b1;
      evt_flags <= `CANRM_RST_ZERO;
      rx_accept <= 1'b0;
      rx_accept_valid <= 1'b0;
      reset_mode <= 1'b1;
      irq <= 1'b0;
    end else begin
      evt_flags <= next_evt;
      // Codes pass through as the engine's bit position
      if (arb_capture) begin
        arb_lost_position <= arb_pos;
        arb_armed <= 1'b0;
      end else if (arb_read && arb_read_ok) begin
        // A byte fetched before the newest capture does not rearm
        arb_armed <= 1'b1;
      end
      rx_accept_valid <= rx_check;
      if (rx_check) begin
        rx_accept <= next_accept;
      end
      // Registered copy of the mode bit, one cycle late
      reset_mode <= mode_control[`CANRM_MODE_RESET];
      // Level output; enable and mask both gate it
      irq <= |(next_evt & interrupt_enables & evt_mask);
    end
  end

endmodule

/* File: canrm_monitor.sv */
`timescale 1ns/10ps
module canrm_monitor (
  input wire clk,
  input wire rst_n,
  input wire [9:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_check,
  input wire rx_accept_valid,
  input wire reset_mode,
  input wire [103:0] tx_frame
);
  // Completed read, its index, and the tx byte that index names
  wire rd = psel && penable && pready && !pwrite;
  wire [7:0] ix = paddr[9:2];
  wire [103:0] txs = tx_frame >> ((ix - 8'h60) * 8);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cmd; rd && ix == 8'h01 |-> prdata == 32'h0; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd read");
  property p_rsv;
    rd && ix > 8'h6c && ix < 8'h80 |-> prdata == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read");
  property p_arb; rd && ix == 8'h0b |-> prdata[31:5] == 27'h0; endproperty
  a_arb: assert property (p_arb) else $error("position high bits");
  // Mode port lags one cycle, which matches when read data is formed
  property p_rsw;
    rd && reset_mode && ix > 8'h17 && ix < 8'h1d |-> prdata == 32'h0;
  endproperty
  a_rsw: assert property (p_rsw) else $error("reset window read");
  property p_txb;
    rd && ix > 8'h5f && ix < 8'h6d |-> prdata[7:0] == txs[7:0];
  endproperty
  a_txb: assert property (p_txb) else $error("tx readback");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_err;
    psel && penable && pready && ix > 8'h81 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_acc; rx_accept_valid == $past(rx_check); endproperty
  a_acc: assert property (p_acc) else $error("decision timing");
endmodule

bind canrm_top canrm_monitor u_canrm_monitor (.clk, .rst_n, .paddr, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .rx_check,
  .rx_accept_valid, .reset_mode, .tx_frame);

/* File: canrm_eng_model.sv */
`timescale 1ns/10ps
module canrm_eng_model (
  input wire clk,
  output logic [103:0] rx_window,
  output logic arb_lost,
  output logic [4:0] arb_pos,
  output logic rx_check,
  output logic [28:0] rx_id,
  output logic rx_rtr,
  output logic rx_ext
);
  // Window byte n holds 80h+n, so a wrong byte lane shows up
  initial begin
    rx_window = 104'h8c8b8a89888786858483828180;
    {arb_lost, arb_pos, rx_check, rx_id, rx_rtr, rx_ext} = 38'h0;
  end
  // One-cycle loss pulse; the code is scrambled once it lapses
  task lose(input logic [4:0] p);
    begin
      {arb_pos, arb_lost} <= {p, 1'b1};
      @(posedge clk);
      {arb_pos, arb_lost} <= {~p, 1'b0};
      @(posedge clk);
    end
  endtask
  // One-cycle decision request; returns when the answer is due
  task check(input logic [28:0] id, input logic r, input logic e);
    begin
      {rx_id, rx_rtr, rx_ext, rx_check} <= {id, r, e, 1'b1};
      @(posedge clk);
      {rx_id, rx_check} <= {~id, 1'b0};
      @(posedge clk);
    end
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, er;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] rd;
  logic [7:0] eng_stat = 8'h00, eng_err = 8'h00, eng_pend = 8'h00;
  wire [7:0] cmd_pulse;
  int miscompares = 0, checked = 0, cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, arb_lost, rx_check, rx_rtr, rx_ext, rx_accept;
  wire rx_accept_valid, reset_mode, irq;
  wire [4:0] arb_pos;
  wire [28:0] rx_id;
  wire [103:0] rx_window, tx_frame;
  // Steps {read, index, data}: reset mode first, then operating mode
  logic [16:0] seq [28] = '{
    17'h1_00_01, 17'h1_0d_60, 17'h1_17_ff, 17'h0_10_12, 17'h0_11_30,
    17'h0_14_00, 17'h0_15_2f, 17'h1_11_30, 17'h1_15_2f, 17'h0_06_5a,
    17'h1_06_5a, 17'h0_18_77, 17'h1_18_00, 17'h1_01_00, 17'h0_00_00,
    17'h0_06_a5, 17'h1_06_5a, 17'h0_10_a5, 17'h0_1c_3c, 17'h0_60_11,
    17'h1_60_a5, 17'h1_6c_3c, 17'h1_10_80, 17'h1_1c_8c, 17'h0_6d_11,
    17'h1_6d_00, 17'h0_04_40, 17'h0_81_40};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  canrm_top u_canrm_top (.clk(clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_status(eng_stat), .engine_err_code(eng_err),
    .engine_pending(eng_pend), .rx_window(rx_window), .arb_lost(arb_lost),
    .arb_pos(arb_pos), .rx_check(rx_check), .rx_id(rx_id),
    .rx_rtr(rx_rtr), .rx_ext(rx_ext), .rx_accept(rx_accept),
    .rx_accept_valid(rx_accept_valid), .cmd_pulse(cmd_pulse), .irq(irq),
    .reset_mode(reset_mode), .tx_frame(tx_frame));
  canrm_eng_model u_eng (.clk(clk), .rx_window(rx_window),
    .arb_lost(arb_lost), .arb_pos(arb_pos), .rx_check(rx_check),
    .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ext(rx_ext));

  task chk(input logic [7:0] g, input logic [7:0] e);
    begin
      checked++;
      if (g !== e) begin
        miscompares++;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // One APB transfer, held until pready, then one idle cycle
  task run(input logic [16:0] s);
    begin
      psel <= 1'b1;
      pwrite <= !s[16];
      paddr <= {s[15:8], 2'b00};
      pwdata <= {24'h0, s[7:0]};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (s[16]) chk(rd, s[7:0]);
    end
  endtask

  task print_verdict;
    begin
      $display("Checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // Cycle ceiling, far above the under two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    {eng_stat, eng_err, eng_pend} <= 24'h96a305;
    @(posedge clk);
    for (int i = 0; i < 28; i++) run(seq[i]);
    chk({7'h0, reset_mode}, 8'h00);
    run(17'h1_02_96);
    run(17'h1_0c_a3);
    run(17'h1_1d_05);
    run(17'h0_01_05);
    chk(cmd_pulse, 8'h05);
    u_eng.check({11'h091, 18'h0}, 1'b1, 1'b0);
    chk({7'h0, rx_accept}, 8'h01);
    u_eng.check({11'h090, 18'h0}, 1'b1, 1'b0);
    chk({7'h0, rx_accept}, 8'h01);
    u_eng.check({11'h0b1, 18'h0}, 1'b1, 1'b0);
    chk({7'h0, rx_accept}, 8'h00);
    u_eng.check({11'h091, 18'h0}, 1'b0, 1'b0);
    chk({7'h0, rx_accept}, 8'h00);
    u_eng.check({11'h091, 18'h0}, 1'b1, 1'b1);
    chk({7'h0, rx_accept}, 8'h00);
    run(17'h0_00_08);
    u_eng.check({11'h0b1, 18'h0}, 1'b1, 1'b0);
    chk({7'h0, rx_accept}, 8'h01);
    u_eng.lose(5'd12);
    u_eng.lose(5'd3);
    chk({7'h0, irq}, 8'h01);
    run(17'h1_0b_0c);
    u_eng.lose(5'd10);
    run(17'h1_0b_0a);
    u_eng.lose(5'd11);
    run(17'h1_0b_0b);
    run(17'h0_80_40);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    run(17'h0_81_00);
    u_eng.lose(5'd1);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    run(17'h1_03_40);
    run(17'h1_80_41);
    run(17'h0_ff_00);
    chk({7'h0, er}, 8'h01);
    print_verdict;
  end
endmodule
